// File: rtl/eqcx_quad.sv
// per-quad equalizer, signal detect, dfe and cross point control with channel registers
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (R01) signal detect gates data path, overridable
// (R02) ctle searches candidates by merit score
// (R03) boost frozen until re-adapt or reacquisition
// (R04) host pulses cdr reset bits to re-adapt
// (R05) four ctle stages, two boost bits each
// (R06) thirty-two entry reprogrammable equalizer table
// (R07) search length limited from one to 32
// (R08) total boost is sum of stages
// (R09) bandwidth full, mid or half
// (R10) fourth stage may become limiting
// (R11) non-blocking 4x4 cross point per quad
// (R12) data mux and mirrored control-bus mux
// (R13) routed equalizer controlled by cdr channel
// (R14) host sets muxes, enables, then resets cdr
// (R15) host enables both buffers when crossing
// (R16) broadcast one input to two-four outputs
// (R17) single master adapts ctle, slaves dfe
// (R18) host sets master bit, resets cdr
// (R19) dfe off until enabled; acquisition or continuous
// (R20) host disables dfe auto-adapt before manual taps
// (R21) tap weights in seven millivolt steps
// (R22) vga code decodes to 0, 6, 12 dB
// (R23) table entry packs four stage fields
module eqcx_quad #(
  parameter int NCH   = eqcx_pkg::NCH,
  parameter int DWELL = eqcx_pkg::DWELL_CYC
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // channel register access
  input  wire logic [1:0]        reg_ch,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  // analog status per channel
  input  wire logic [NCH-1:0]    sig_det,
  input  wire logic [NCH-1:0]    cdr_lock,
  input  wire logic [NCH*8-1:0]  fom,
  // per physical equalizer
  output logic      [NCH*8-1:0]  eq_boost,
  output logic      [NCH*4-1:0]  eq_boost_sum,
  output logic      [NCH*2-1:0]  eq_bw,
  output logic      [NCH-1:0]    eq_limit,
  // per channel data path
  output logic      [NCH-1:0]    path_power,
  output logic      [NCH-1:0]    cdr_reset,
  output logic      [NCH*2-1:0]  dmux_sel,
  output logic      [NCH-1:0]    local_buf_en,
  output logic      [NCH-1:0]    mdrv_buf_en,
  output logic      [NCH-1:0]    xp_enable,
  output logic      [NCH-1:0]    adapt_done,
  // per channel dfe and vga
  output logic      [NCH-1:0]    dfe_enable,
  output logic      [NCH-1:0]    dfe_adapt,
  output logic      [NCH*35-1:0] dfe_taps,
  output logic      [NCH*2-1:0]  vga_level
);
  logic [7:0] r_cdr  [NCH];
  logic [7:0] r_sd   [NCH];
  logic [7:0] r_ctle [NCH];
  logic [7:0] r_dfe  [NCH];
  logic [7:0] r_vga  [NCH];
  logic [7:0] r_xpd  [NCH];
  logic [7:0] r_xpc  [NCH];
  logic [7:0] r_tap  [NCH][eqcx_pkg::NTAP];
  logic [7:0] r_eq   [NCH][eqcx_pkg::TAB_DEPTH];
  logic [7:0] next_cdr  [NCH];
  logic [7:0] next_sd   [NCH];
  logic [7:0] next_ctle [NCH];
  logic [7:0] next_dfe  [NCH];
  logic [7:0] next_vga  [NCH];
  logic [7:0] next_xpd  [NCH];
  logic [7:0] next_xpc  [NCH];
  logic [7:0] next_tap  [NCH][eqcx_pkg::NTAP];
  logic [7:0] next_eq   [NCH][eqcx_pkg::TAB_DEPTH];
  logic [7:0] next_rdata;
  logic       in_reset  [NCH];
  logic       rst_q     [NCH];
  logic       lock_q    [NCH];
  logic       acquiring [NCH];
  logic       next_acq  [NCH];
  logic       start     [NCH];
  logic       allow     [NCH];
  logic [4:0] idx       [NCH];
  logic [7:0] a_boost   [NCH];
  logic       a_done    [NCH];

  // register file writes and read mux
  always_comb begin
    next_cdr   = r_cdr;
    next_sd    = r_sd;
    next_ctle  = r_ctle;
    next_dfe   = r_dfe;
    next_vga   = r_vga;
    next_xpd   = r_xpd;
    next_xpc   = r_xpc;
    next_tap   = r_tap;
    next_eq    = r_eq;
    next_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        eqcx_pkg::A_CDR_RST:  next_cdr[reg_ch]  = reg_wdata;
        eqcx_pkg::A_SIGDET:   next_sd[reg_ch]   = reg_wdata;
        eqcx_pkg::A_CTLE_CFG: next_ctle[reg_ch] = reg_wdata;
        eqcx_pkg::A_DFE_CFG:  next_dfe[reg_ch]  = reg_wdata;
        eqcx_pkg::A_VGA:      next_vga[reg_ch]  = reg_wdata;
        eqcx_pkg::A_XP_DATA:  next_xpd[reg_ch]  = reg_wdata;
        eqcx_pkg::A_XP_CBUS:  next_xpc[reg_ch]  = reg_wdata;
        default: begin
          if (reg_addr >= eqcx_pkg::A_EQ_FIRST && reg_addr <= eqcx_pkg::A_EQ_LAST) begin
            next_eq[reg_ch][reg_addr[4:0]] = reg_wdata; // R06
          end
          if (reg_addr >= eqcx_pkg::A_TAP_FIRST && reg_addr <= eqcx_pkg::A_TAP_LAST) begin
            next_tap[reg_ch][3'(reg_addr - eqcx_pkg::A_TAP_FIRST)] = reg_wdata;
          end
        end
      endcase
    end
    case (reg_addr)
      eqcx_pkg::A_CDR_RST:  next_rdata = r_cdr[reg_ch];
      eqcx_pkg::A_SIGDET:   next_rdata = r_sd[reg_ch];
      eqcx_pkg::A_CTLE_CFG: next_rdata = r_ctle[reg_ch];
      eqcx_pkg::A_DFE_CFG:  next_rdata = r_dfe[reg_ch];
      eqcx_pkg::A_VGA:      next_rdata = r_vga[reg_ch];
      eqcx_pkg::A_XP_DATA:  next_rdata = r_xpd[reg_ch];
      eqcx_pkg::A_XP_CBUS:  next_rdata = r_xpc[reg_ch];
      eqcx_pkg::A_STATUS:   next_rdata = {5'h00, path_power[reg_ch], acquiring[reg_ch], a_done[reg_ch]};
      eqcx_pkg::A_BOOST_RD: next_rdata = a_boost[reg_ch];
      default: begin
        if (reg_addr >= eqcx_pkg::A_EQ_FIRST && reg_addr <= eqcx_pkg::A_EQ_LAST) begin
          next_rdata = r_eq[reg_ch][reg_addr[4:0]];
        end
        if (reg_addr >= eqcx_pkg::A_TAP_FIRST && reg_addr <= eqcx_pkg::A_TAP_LAST) begin
          next_rdata = r_tap[reg_ch][3'(reg_addr - eqcx_pkg::A_TAP_FIRST)];
        end
      end
    endcase
    if (!reg_rd) begin
      next_rdata = reg_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        r_cdr[c]  <= eqcx_pkg::RST_ZERO;
        r_sd[c]   <= eqcx_pkg::RST_ZERO;
        r_ctle[c] <= eqcx_pkg::RST_CTLE_CFG;
        r_dfe[c]  <= eqcx_pkg::RST_ZERO;
        r_vga[c]  <= eqcx_pkg::RST_VGA;
        r_xpd[c]  <= eqcx_pkg::RST_ZERO;
        r_xpc[c]  <= eqcx_pkg::RST_ZERO;
        for (int t = 0; t < eqcx_pkg::NTAP; t++) begin
          r_tap[c][t] <= eqcx_pkg::RST_ZERO;
        end
        for (int e = 0; e < eqcx_pkg::TAB_DEPTH; e++) begin
          r_eq[c][e] <= eqcx_pkg::RST_EQ_ENTRY;
        end
      end
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      r_cdr      <= next_cdr;
      r_sd       <= next_sd;
      r_ctle     <= next_ctle;
      r_dfe      <= next_dfe;
      r_vga      <= next_vga;
      r_xpd      <= next_xpd;
      r_xpc      <= next_xpc;
      r_tap      <= next_tap;
      r_eq       <= next_eq;
      reg_rdata  <= next_rdata;
      reg_rvalid <= reg_rd;
    end
  end

  // lock acquisition tracking; release of cdr reset or lock loss restarts the search
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      in_reset[c] = r_cdr[c][eqcx_pkg::B_CDR_RST_HI] & r_cdr[c][eqcx_pkg::B_CDR_RST_LO];
      start[c]    = (rst_q[c] & ~in_reset[c]) | (lock_q[c] & ~cdr_lock[c]); // R03
      next_acq[c] = in_reset[c] ? 1'b0 : (start[c] ? 1'b1 : (acquiring[c] & ~cdr_lock[c]));
      // a slave in a crossed group never drives the ctle search
      allow[c]    = ~r_xpd[c][eqcx_pkg::B_XP_EN] | r_xpd[c][eqcx_pkg::B_XP_MASTER]; // R17
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        rst_q[c]     <= 1'b0;
        lock_q[c]    <= 1'b0;
        acquiring[c] <= 1'b0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        rst_q[c]     <= in_reset[c];
        lock_q[c]    <= cdr_lock[c];
        acquiring[c] <= next_acq[c];
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_adapt
    eqcx_adapt #(
      .DWELL (DWELL)
    ) u_adapt (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .start  (start[g]),
      .allow  (allow[g]),
      .len_m1 (r_ctle[g][eqcx_pkg::B_LEN_HI:eqcx_pkg::B_LEN_LO]), // R07
      .entry  (r_eq[g][idx[g]]), // R06
      .fom    (fom[g*8 +: 8]),
      .idx    (idx[g]),
      .boost  (a_boost[g]),
      .done   (a_done[g])
    );
  end

  // output decode; every output leaves from a flip-flop
  logic [NCH*8-1:0]  next_eq_boost;
  logic [NCH*4-1:0]  next_eq_sum;
  logic [NCH*2-1:0]  next_eq_bw;
  logic [NCH-1:0]    next_eq_limit;
  logic [NCH-1:0]    next_power;
  logic [NCH*35-1:0] next_taps;
  logic [NCH*2-1:0]  next_vga_level;
  logic [1:0]        own;
  logic              hit;
  logic [1:0]        src;
  logic [5:0]        w;

  always_comb begin
    next_eq_boost  = '0;
    next_eq_sum    = '0;
    next_eq_bw     = '0;
    next_eq_limit  = '0;
    next_power     = '0;
    next_taps      = '0;
    next_vga_level = '0;
    own            = 2'h0;
    hit            = 1'b0;
    src            = 2'h0;
    w              = 6'h00;
    for (int p = 0; p < NCH; p++) begin
      // equalizer answers to the channel whose control bus selects it, master first
      own = 2'(p);
      hit = 1'b0;
      for (int c = 0; c < NCH; c++) begin
        if (r_xpd[c][eqcx_pkg::B_XP_EN] && r_xpc[c][1:0] == 2'(p)
            && (!hit || r_xpd[c][eqcx_pkg::B_XP_MASTER])) begin // R13
          own = 2'(c);
          hit = 1'b1;
        end
      end
      next_eq_boost[p*8 +: 8] = a_boost[own]; // R23
      next_eq_sum[p*4 +: 4]   = 4'(a_boost[own][1:0]) + 4'(a_boost[own][3:2])
                              + 4'(a_boost[own][5:4]) + 4'(a_boost[own][7:6]); // R05 R08
      case (r_ctle[own][eqcx_pkg::B_BW_HI:eqcx_pkg::B_BW_LO]) // R09
        eqcx_pkg::BW_MID:  next_eq_bw[p*2 +: 2] = eqcx_pkg::BW_MID;
        eqcx_pkg::BW_HALF: next_eq_bw[p*2 +: 2] = eqcx_pkg::BW_HALF;
        default:           next_eq_bw[p*2 +: 2] = eqcx_pkg::BW_FULL;
      endcase
      next_eq_limit[p] = r_ctle[own][eqcx_pkg::B_LIMIT]; // R10
    end
    for (int c = 0; c < NCH; c++) begin
      src = r_xpd[c][eqcx_pkg::B_XP_EN] ? r_xpc[c][1:0] : 2'(c); // R12
      next_power[c] = r_sd[c][eqcx_pkg::B_SD_OVR] ? r_sd[c][eqcx_pkg::B_SD_FORCE] : sig_det[src]; // R01
      for (int t = 0; t < eqcx_pkg::NTAP; t++) begin
        w = r_tap[c][t][eqcx_pkg::B_TAP_W_HI:0];
        // out-of-range weight codes saturate at the tap's top step
        if (t == 0 && w > eqcx_pkg::TAP1_MAX_CODE) begin // R21
          w = eqcx_pkg::TAP1_MAX_CODE;
        end
        if (t != 0 && w > eqcx_pkg::TAPN_MAX_CODE) begin // R21
          w = eqcx_pkg::TAPN_MAX_CODE;
        end
        next_taps[c*35 + t*7 +: 7] = {r_tap[c][t][eqcx_pkg::B_TAP_POL], w}; // R21
      end
      case (r_vga[c][eqcx_pkg::B_VGA_HI:0]) // R22
        2'h1, 2'h2: next_vga_level[c*2 +: 2] = eqcx_pkg::VGA_6DB;
        2'h3:       next_vga_level[c*2 +: 2] = eqcx_pkg::VGA_12DB;
        default:    next_vga_level[c*2 +: 2] = eqcx_pkg::VGA_0DB;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      eq_boost     <= '0;
      eq_boost_sum <= '0;
      eq_bw        <= '0;
      eq_limit     <= '0;
      path_power   <= '0;
      cdr_reset    <= '0;
      dmux_sel     <= '0;
      local_buf_en <= '0;
      mdrv_buf_en  <= '0;
      xp_enable    <= '0;
      adapt_done   <= '0;
      dfe_enable   <= '0;
      dfe_adapt    <= '0;
      dfe_taps     <= '0;
      vga_level    <= '0;
    end else begin
      eq_boost     <= next_eq_boost;
      eq_boost_sum <= next_eq_sum;
      eq_bw        <= next_eq_bw;
      eq_limit     <= next_eq_limit;
      path_power   <= next_power;
      dfe_taps     <= next_taps;
      vga_level    <= next_vga_level;
      for (int c = 0; c < NCH; c++) begin
        cdr_reset[c]       <= in_reset[c];
        dmux_sel[c*2 +: 2] <= r_xpd[c][eqcx_pkg::B_XP_SEL_HI:0]; // R11 R16
        local_buf_en[c]    <= r_xpd[c][eqcx_pkg::B_XP_LBUF];
        mdrv_buf_en[c]     <= r_xpd[c][eqcx_pkg::B_XP_MBUF];
        xp_enable[c]       <= r_xpd[c][eqcx_pkg::B_XP_EN]; // R11
        adapt_done[c]      <= a_done[c] & allow[c];
        dfe_enable[c]      <= r_dfe[c][eqcx_pkg::B_DFE_EN]; // R19
        // slaves still adapt their own dfe
        dfe_adapt[c]       <= r_dfe[c][eqcx_pkg::B_DFE_EN] & r_dfe[c][eqcx_pkg::B_DFE_AUTO]
                              & (r_dfe[c][eqcx_pkg::B_DFE_CONT] | acquiring[c]); // R19 R17
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/eqcx_pkg.sv
// constants for the quad equalizer and cross point control block
package eqcx_pkg;
  localparam int          NCH           = 4;
  localparam int          TAB_DEPTH     = 32;
  localparam int          NTAP          = 5;
  localparam int          MCLK_MHZ      = 40;

  // channel register offsets
  localparam logic [7:0]  A_CDR_RST     = 8'h0a;
  localparam logic [7:0]  A_SIGDET      = 8'h14;
  localparam logic [7:0]  A_CTLE_CFG    = 8'h33;
  localparam logic [7:0]  A_DFE_CFG     = 8'h34;
  localparam logic [7:0]  A_TAP_FIRST   = 8'h35;
  localparam logic [7:0]  A_TAP_LAST    = 8'h39;
  localparam logic [7:0]  A_STATUS      = 8'h3a;
  localparam logic [7:0]  A_BOOST_RD    = 8'h3b;
  localparam logic [7:0]  A_EQ_FIRST    = 8'h40;
  localparam logic [7:0]  A_EQ_LAST     = 8'h5f;
  localparam logic [7:0]  A_VGA         = 8'h8e;
  localparam logic [7:0]  A_XP_DATA     = 8'h96;
  localparam logic [7:0]  A_XP_CBUS     = 8'h9b;

  // reset values
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam logic [7:0]  RST_CTLE_CFG  = 8'h1f;
  localparam logic [7:0]  RST_VGA       = 8'h1c;
  localparam logic [7:0]  RST_EQ_ENTRY  = 8'h00;

  // field positions
  localparam int          B_CDR_RST_LO  = 2;
  localparam int          B_CDR_RST_HI  = 3;
  localparam int          B_SD_FORCE    = 0;
  localparam int          B_SD_OVR      = 1;
  localparam int          B_LEN_LO      = 0;
  localparam int          B_LEN_HI      = 4;
  localparam int          B_BW_LO       = 5;
  localparam int          B_BW_HI       = 6;
  localparam int          B_LIMIT       = 7;
  localparam int          B_DFE_EN      = 0;
  localparam int          B_DFE_CONT    = 1;
  localparam int          B_DFE_AUTO    = 2;
  localparam int          B_TAP_W_HI    = 5;
  localparam int          B_TAP_POL     = 7;
  localparam int          B_VGA_HI      = 1;
  localparam int          B_XP_SEL_HI   = 1;
  localparam int          B_XP_LBUF     = 2;
  localparam int          B_XP_MBUF     = 3;
  localparam int          B_XP_EN       = 4;
  localparam int          B_XP_MASTER   = 5;

  // dfe tap weight limits, in steps of the tap step size
  localparam int          TAP_STEP_MV   = 7;
  localparam int          TAP1_MAX_MV   = 224;
  localparam int          TAPN_MAX_MV   = 112;
  localparam logic [5:0]  TAP1_MAX_CODE = 6'(TAP1_MAX_MV / TAP_STEP_MV);
  localparam logic [5:0]  TAPN_MAX_CODE = 6'(TAPN_MAX_MV / TAP_STEP_MV);

  // dwell per table candidate before the merit score is taken
  localparam int          FOM_DWELL_NS  = 1000;
  localparam int          DWELL_CYC     = (FOM_DWELL_NS * MCLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {BW_FULL = 2'h0, BW_MID = 2'h1, BW_HALF = 2'h2} eqcx_bw_t;
  typedef enum logic [1:0] {VGA_0DB = 2'h0, VGA_6DB = 2'h1, VGA_12DB = 2'h2} eqcx_vga_t;
endpackage

// File: rtl/eqcx_adapt.sv
// ctle boost search over the equalizer table for one channel
`timescale 1ns/10ps
`default_nettype none
module eqcx_adapt #(
  parameter int DWELL = eqcx_pkg::DWELL_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // control
  input  wire logic       start,
  input  wire logic       allow,
  input  wire logic [4:0] len_m1,
  // table and score
  input  wire logic [7:0] entry,
  input  wire logic [7:0] fom,
  output logic      [4:0] idx,
  // result
  output logic      [7:0] boost,
  output logic            done
);
  typedef enum {S_IDLE, S_DWELL, S_FROZEN} eqcx_ast_t;
  eqcx_ast_t   st;
  eqcx_ast_t   next_st;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [7:0]  best;
  logic [7:0]  next_best;
  logic [7:0]  best_code;
  logic [7:0]  next_best_code;
  logic [4:0]  next_idx;
  logic [7:0]  next_boost;

  always_comb begin
    next_st        = st;
    next_cnt       = cnt;
    next_best      = best;
    next_best_code = best_code;
    next_idx       = idx;
    next_boost     = boost;
    case (st)
      S_IDLE, S_FROZEN: begin
        // frozen boost holds until the next lock acquisition
        if (start && allow) begin // R03
          next_st   = S_DWELL;
          next_idx  = 5'h00;
          next_cnt  = 16'h0000;
          next_best = 8'h00;
        end
      end
      S_DWELL: begin
        next_boost = entry; // R02
        if (cnt == 16'(DWELL - 1)) begin
          next_cnt = 16'h0000;
          if (fom > best || idx == 5'h00) begin // R02
            next_best      = fom;
            next_best_code = entry;
          end
          if (idx == len_m1) begin // R07
            next_st    = S_FROZEN;
            next_boost = (fom > best || idx == 5'h00) ? entry : best_code; // R03
          end else begin
            next_idx = idx + 5'h01;
          end
        end else begin
          next_cnt = cnt + 16'h0001;
        end
        if (start) begin
          next_idx = 5'h00;
          next_cnt = 16'h0000;
        end
        if (!allow) begin
          next_st = S_IDLE;
        end
      end
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st        <= S_IDLE;
      cnt       <= 16'h0000;
      best      <= 8'h00;
      best_code <= 8'h00;
      idx       <= 5'h00;
      boost     <= 8'h00;
    end else begin
      st        <= next_st;
      cnt       <= next_cnt;
      best      <= next_best;
      best_code <= next_best_code;
      idx       <= next_idx;
      boost     <= next_boost;
    end
  end

  assign done = (st == S_FROZEN);
endmodule
`default_nettype wire

// File: tb/eqcx_quad_asserts.sv
// port assertions for the quad equalizer and cross point control
`timescale 1ns/10ps
`default_nettype none
module eqcx_quad_asserts #(
  parameter int NCH   = 4,
  parameter int DWELL = 40
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [1:0]        reg_ch,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_rdata,
  input  wire logic              reg_rvalid,
  // watched outputs
  input  wire logic [NCH*8-1:0]  eq_boost,
  input  wire logic [NCH-1:0]    cdr_reset,
  input  wire logic [NCH-1:0]    xp_enable,
  input  wire logic [NCH-1:0]    adapt_done,
  input  wire logic [NCH-1:0]    dfe_enable,
  input  wire logic [NCH-1:0]    dfe_adapt,
  input  wire logic [NCH*2-1:0]  vga_level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_stray;
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray read valid");
  property p_rdata_hold;
    !reg_rvalid |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_unmapped;
    reg_rd && reg_addr == 8'hff |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_vga;
    reg_wr && reg_ch == 2'h1 && reg_addr == 8'h8e && reg_wdata[1:0] == 2'h3 |=> ##1 vga_level[3:2] == 2'h2;
  endproperty
  a_vga: assert property (p_vga) else $error("vga code 3 not 12 dB");
  property p_cdr_rst;
    reg_wr && reg_ch == 2'h0 && reg_addr == 8'h0a && reg_wdata[3:2] == 2'h3 |=> ##1 cdr_reset[0];
  endproperty
  a_cdr_rst: assert property (p_cdr_rst) else $error("cdr reset not applied");
  // routing changes move the owner, so only straight mode is judged
  property p_freeze;
    adapt_done[0] && $past(adapt_done[0]) && xp_enable == 4'h0 && $past(xp_enable) == 4'h0
      |-> $stable(eq_boost[7:0]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen boost moved");
  property p_dfe_off;
    !dfe_enable[1] |-> !dfe_adapt[1];
  endproperty
  a_dfe_off: assert property (p_dfe_off) else $error("dfe adapts while off");

  c_done: cover property ($rose(adapt_done[0]));
  c_vga: cover property (vga_level[3:2] == 2'h2);
  c_xp: cover property (xp_enable == 4'hf);
endmodule
bind eqcx_quad eqcx_quad_asserts #(.NCH(NCH), .DWELL(DWELL)) i_chk (.mclk, .rst_n, .reg_ch, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .eq_boost, .cdr_reset, .xp_enable, .adapt_done,
  .dfe_enable, .dfe_adapt, .vga_level);
`default_nettype wire

// File: tb/eqcx_link_model.sv
// link side model: merit score peaks as the boost code nears a target
`timescale 1ns/10ps
`default_nettype none
module eqcx_link_model (
  // clock
  input  wire logic         mclk,
  // from the block
  input  wire logic [31:0]  eq_boost,
  input  wire logic [3:0]   cdr_reset,
  input  wire logic [3:0]   adapt_done,
  // from the bench
  input  wire logic [31:0]  best,
  input  wire logic [3:0]   lock_drop,
  // to the block
  output logic      [31:0]  fom,
  output var logic  [3:0]   cdr_lock
);
  function automatic logic [7:0] gap(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a - b : b - a;
  endfunction
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      fom[8*c +: 8] = 8'hff - gap(eq_boost[8*c +: 8], best[8*c +: 8]);
    end
  end
  // lock only once the search settles; a drop forces reacquisition
  always_ff @(posedge mclk) cdr_lock <= ~cdr_reset & adapt_done & ~lock_drop;
endmodule
`default_nettype wire

// File: tb/eqcx_quad_tb.sv
// self-checking bench for the quad equalizer and cross point control
`timescale 1ns/10ps
`default_nettype none
module eqcx_quad_tb;
  localparam int DW = 8;
  logic        mclk, rst_n, reg_wr, reg_rd, reg_rvalid;
  logic [1:0]  reg_ch;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  sig_det, cdr_lock, eq_limit, path_power, cdr_reset, lbe, mbe, xp_enable, adapt_done;
  logic [3:0]  dfe_enable, dfe_adapt, lock_drop;
  logic [31:0] fom, eq_boost, best;
  logic [15:0] eq_boost_sum;
  logic [7:0]  eq_bw, dmux_sel, vga_level;
  logic [139:0] dfe_taps;
  logic [7:0]  tab [32];
  logic [7:0]  exp_q [$];
  logic [7:0]  r;
  int          err_total, check_count, cyc_count, seed;

  eqcx_quad #(.DWELL(DW)) i_dut (.mclk, .rst_n, .reg_ch, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .sig_det, .cdr_lock, .fom, .eq_boost, .eq_boost_sum, .eq_bw, .eq_limit, .path_power,
    .cdr_reset, .dmux_sel, .local_buf_en(lbe), .mdrv_buf_en(mbe), .xp_enable, .adapt_done, .dfe_enable,
    .dfe_adapt, .dfe_taps, .vga_level);
  eqcx_link_model i_link (.mclk, .eq_boost, .cdr_reset, .adapt_done, .best, .lock_drop, .fom, .cdr_lock);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic stop_test;
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_ch = ch;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_ch = ch;
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask
  // read answers are matched oldest first against what the driver noted
  always @(negedge mclk) begin
    if (rst_n && reg_rvalid) begin
      if (exp_q.size() == 0) chk(8'h01, 8'h00);
      else chk(reg_rdata, exp_q.pop_front());
    end
  end
  always @(posedge mclk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      err_total++;
      stop_test();
    end
  end

  function automatic logic [7:0] bsum(input logic [7:0] x);
    return 8'(x[1:0]) + 8'(x[3:2]) + 8'(x[5:4]) + 8'(x[7:6]);
  endfunction
  // first entry with strictly smallest distance wins, as strictly greatest score
  function automatic logic [7:0] pick(input int n, input logic [7:0] b);
    logic [7:0] w;
    int bd, d;
    w = tab[0];
    bd = 999;
    for (int i = 0; i < n; i++) begin
      d = (tab[i] > b) ? int'(tab[i] - b) : int'(b - tab[i]);
      if (d < bd) begin
        bd = d;
        w = tab[i];
      end
    end
    return w;
  endfunction
  task automatic adapt(input int n);
    logic [7:0] b;
    b = 8'($urandom);
    best[7:0] = b;
    wr(2'h0, eqcx_pkg::A_CTLE_CFG, {3'h3, 5'(n - 1)});
    wr(2'h0, eqcx_pkg::A_CDR_RST, 8'h0c);
    wr(2'h0, eqcx_pkg::A_CDR_RST, 8'h00);
    cyc(n * DW + 20);
    chk(adapt_done[0], 1'b1);
    chk(eq_boost[7:0], pick(n, b));
    chk(eq_boost_sum[3:0], bsum(pick(n, b)));
    best[7:0] = ~b;
    cyc(20);
    chk(eq_boost[7:0], pick(n, b));
    lock_drop[0] = 1'b1;
    // hold the drop until done has fallen, so lock does not blip
    cyc(3);
    lock_drop[0] = 1'b0;
    cyc(n * DW + 20);
    chk(eq_boost[7:0], pick(n, ~b));
  endtask

  initial begin
    {rst_n, reg_wr, reg_rd, reg_ch, reg_addr, reg_wdata} = '0;
    {best, lock_drop, sig_det} = '0;
    seed = $urandom(91);
    cyc(5);
    rst_n = 1'b1;
    cyc(1);
    rd(2'h0, eqcx_pkg::A_CTLE_CFG, eqcx_pkg::RST_CTLE_CFG);
    rd(2'h0, eqcx_pkg::A_VGA, eqcx_pkg::RST_VGA);
    rd(2'h0, eqcx_pkg::A_XP_DATA, 8'h00);
    rd(2'h0, 8'hff, 8'h00);
    chk(vga_level, 8'h00);
    chk(eq_bw, 8'h00);
    chk(dfe_enable, 4'h0);
    for (int i = 0; i < 32; i++) begin
      tab[i] = 8'($urandom);
      wr(2'h0, eqcx_pkg::A_EQ_FIRST + 8'(i), tab[i]);
    end
    for (int i = 0; i < 32; i++) rd(2'h0, eqcx_pkg::A_EQ_FIRST + 8'(i), tab[i]);
    adapt(32);
    adapt(1);
    adapt(2 + int'($urandom % 30));
    // signal detect gating and its override
    cyc(3);
    chk(path_power[3], 1'b0);
    sig_det = 4'hf;
    cyc(3);
    chk(path_power[3], 1'b1);
    wr(2'h3, eqcx_pkg::A_SIGDET, 8'h02);
    cyc(3);
    chk(path_power[3], 1'b0);
    wr(2'h3, eqcx_pkg::A_SIGDET, 8'h03);
    sig_det[3] = 1'b0;
    cyc(3);
    chk(path_power[3], 1'b1);
    for (int v = 0; v < 4; v++) begin
      wr(2'h1, eqcx_pkg::A_VGA, 8'h1c | 8'(v));
      cyc(3);
      chk(vga_level[3:2], (v == 0) ? 8'h0 : (v == 3) ? 8'h2 : 8'h1);
    end
    wr(2'h2, eqcx_pkg::A_CTLE_CFG, 8'h9f);
    wr(2'h1, eqcx_pkg::A_DFE_CFG, 8'h06);
    cyc(3);
    chk(eq_limit[2], 1'b1);
    chk(dfe_enable[1], 1'b0);
    chk(dfe_adapt[1], 1'b0);
    r = 8'($urandom) & 8'h8f;
    wr(2'h1, eqcx_pkg::A_DFE_CFG, 8'h01);
    wr(2'h1, eqcx_pkg::A_TAP_FIRST, 8'hff);
    wr(2'h1, eqcx_pkg::A_TAP_FIRST + 8'h1, 8'h3f);
    wr(2'h1, eqcx_pkg::A_TAP_FIRST + 8'h2, r);
    wr(2'h1, eqcx_pkg::A_DFE_CFG, 8'h07);
    cyc(3);
    chk(dfe_adapt[1], 1'b1);
    chk(dfe_taps[41:35], 8'h60);
    chk(dfe_taps[48:42], 8'h10);
    chk(dfe_taps[55:49], {1'b0, r[7], 2'h0, r[3:0]});
    // swap: ch1 takes equalizer 0, ch0 takes equalizer 1
    wr(2'h1, eqcx_pkg::A_CTLE_CFG, 8'h9f);
    wr(2'h1, eqcx_pkg::A_XP_CBUS, 8'h00);
    wr(2'h1, eqcx_pkg::A_XP_DATA, 8'h1c);
    wr(2'h0, eqcx_pkg::A_XP_CBUS, 8'h01);
    wr(2'h0, eqcx_pkg::A_XP_DATA, 8'h1d);
    wr(2'h1, eqcx_pkg::A_CDR_RST, 8'h0c);
    wr(2'h1, eqcx_pkg::A_CDR_RST, 8'h00);
    cyc(3);
    chk(dmux_sel, 8'h01);
    chk({lbe[1:0], mbe[1:0], xp_enable[1:0]}, 8'h3f);
    chk(eq_limit[1:0], 2'h1);
    // broadcast equalizer 0: ch0 straight through as master, ch1 to ch3 slaves
    wr(2'h0, eqcx_pkg::A_XP_CBUS, 8'h00);
    wr(2'h0, eqcx_pkg::A_XP_DATA, 8'h3c);
    for (int c = 1; c < 4; c++) begin
      wr(2'(c), eqcx_pkg::A_XP_CBUS, 8'h00);
      wr(2'(c), eqcx_pkg::A_XP_DATA, 8'h1c);
    end
    wr(2'h2, eqcx_pkg::A_CDR_RST, 8'h0c);
    wr(2'h2, eqcx_pkg::A_CDR_RST, 8'h00);
    cyc(32 * DW + 20);
    chk(adapt_done[2], 1'b0);
    chk(xp_enable, 4'hf);
    rd(2'h0, eqcx_pkg::A_XP_DATA, 8'h3c);
    cyc(4);
    stop_test();
  end
endmodule
`default_nettype wire
